// ===== inc/wdt_regs.svh
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
// register byte addresses
`define WDT_ADDR_CTRL 12'h000
`define WDT_ADDR_CAUSE 12'h004
`define WDT_ADDR_STAT 12'h008
`define WDT_ADDR_MASK 12'h00C
`define WDT_ADDR_CFG 12'h010
// field positions
`define WDT_EN_BIT 0
`define WDT_TO_BIT 1
`define WDT_PD_BIT 0
`define WDT_EV_TIMEOUT 0
`define WDT_EV_CLEAR 1
// timing
`define WDT_CLK_HZ 50000000
`define WDT_BASE_US 4000
`define WDT_BASE_CYC ((`WDT_CLK_HZ / 1000000) * `WDT_BASE_US)
// reset values
`define WDT_PS_RESET 4'hF
`define WDT_CFG_EN_RESET 1'h1
`endif

// ===== inc/wdt_pkg.sv
package wdt_pkg;
    // controller state, one-hot
    typedef enum logic [2:0] {
        WDT_OFF = 3'h1,
        WDT_RUN = 3'h2,
        WDT_FIRE = 3'h4
    } wdt_state_t;

    // whole block state
    typedef struct packed {
        wdt_state_t st;
        logic [17:0] base_cnt;
        logic [15:0] post_cnt;
        logic soft_en;
        logic cfg_en;
        logic [3:0] period_sel;
        logic timeout_flag;
        logic powerdown_flag;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [31:0] prdata;
    } wdt_regs_t;

    // events toward the core
    typedef struct packed {
        logic reset_req;
        logic wake_req;
    } wdt_evt_t;
endpackage

// ===== hdl/wdt_top.sv
`timescale 1ns/1ps
`include "wdt_regs.svh"
// Function
// - clocked only by rc osc, enable starts it
// - base period nominally 4 ms
// - 16-bit postscaler, tap chosen by config
// - timeout spans 4 ms to ~131 s
// - sleep or clear insn zero both counters
// - oscillator failure clears both counters
// - bit 0 software enable, read/write
// - config enable forces run, ignores bit
// - bits 7-1 read zero, enable resets 0
// - config bits reset to one at power-on
module wdt_top import wdt_pkg::*; (
    input wire logic pclk, // block clock, stands in for rc osc
    input wire logic presetn, // power-on reset, active low
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_insn, // sleep executed, one-cycle pulse
    input wire logic clear_dog_insn, // clear-watchdog executed, pulse
    input wire logic sleeping, // core is in sleep
    input wire logic osc_fail, // primary or secondary clock failure
    output logic internal_rc_osc_en, // requests the rc oscillator on
    output logic dog_reset, // device reset pulse
    output logic dog_wake, // wake-from-sleep pulse
    output logic irq // level interrupt
);
    wdt_regs_t r; // registered state
    wdt_regs_t next_r; // next state
    logic wr; // write access phase
    logic rd; // read access phase
    logic rd_setup; // read setup phase, loads read data early
    logic running; // watchdog active
    logic base_tick; // base period elapsed
    logic expire; // selected tap elapsed
    logic clr; // counter clear
    logic [1:0] ev; // events this cycle
    logic [1:0] w1c; // status clear bits

    // postscaler tap: tap n expires after 2^n base periods
    // the count holds completed base periods, so the tap is hit when
    // the low n bits are all ones at the closing base tick
    // tap 0 has an empty mask and fires on every base tick
    // tap 15 needs 32768 base periods, the longest timeout
    function automatic logic tap_hit(input logic [15:0] cnt, input logic [3:0] sel);
        logic [15:0] lim;
        lim = 16'hFFFF >> (5'h10 - {1'b0, sel});
        return (cnt & lim) == lim;
    endfunction

    // bus phase decode
    // writes land at the access edge; reads are loaded at the setup
    // edge so that the word stands in prdata through the access phase
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    // watchdog run and clear conditions
    // the config enable overrides the software bit
    // any of the three clear sources zeroes both counters
    // a clear in the same cycle as an expiry wins, so a late
    // clear-watchdog never lets the timeout slip through
    assign running = r.cfg_en || r.soft_en;
    assign clr = sleep_insn || clear_dog_insn || osc_fail;
    assign base_tick = r.base_cnt == 18'(`WDT_BASE_CYC - 1);
    assign expire = running && base_tick && tap_hit(r.post_cnt, r.period_sel) && !clr;
    assign ev = {clear_dog_insn, expire};
    assign w1c = (wr && paddr == `WDT_ADDR_STAT) ? pwdata[1:0] : 2'h0;

    // next-state logic
    // one process computes the whole next state; the register
    // process below only copies it, so every field has one driver
    always_comb begin
        next_r = r;
        // counting
        // the base counter wraps once per base period; the postscaler
        // advances on each wrap and is zeroed on expiry
        // while stopped both counters are held at zero, so a restart
        // always begins a full timeout
        if (clr || !running) begin
            next_r.base_cnt = 18'h0;
            next_r.post_cnt = 16'h0;
        end else if (base_tick) begin
            next_r.base_cnt = 18'h0;
            next_r.post_cnt = expire ? 16'h0 : r.post_cnt + 16'h1;
        end else begin
            next_r.base_cnt = r.base_cnt + 18'h1;
        end
        // controller state
        // off: counters held; run: counting; fire: one cycle in which
        // the reset or wake pulse goes out, then back to run or off
        unique case (r.st)
            WDT_OFF: begin
                if (running) begin
                    next_r.st = WDT_RUN;
                end
            end
            WDT_RUN: begin
                if (expire) begin
                    next_r.st = WDT_FIRE;
                end else if (!running) begin
                    next_r.st = WDT_OFF;
                end
            end
            WDT_FIRE: begin
                next_r.st = running ? WDT_RUN : WDT_OFF;
            end
        endcase
        // reset-cause flags
        // expiry clears the timeout flag so software can tell a
        // watchdog reset from a power-on one; the clear and sleep
        // instructions set it again, sleep also clears powerdown
        if (expire) begin
            next_r.timeout_flag = 1'b0;
        end else if (clear_dog_insn) begin
            next_r.timeout_flag = 1'b1;
            next_r.powerdown_flag = 1'b1;
        end else if (sleep_insn) begin
            next_r.timeout_flag = 1'b1;
            next_r.powerdown_flag = 1'b0;
        end
        // register writes
        // the soft enable is stored even while the config enable
        // forces the watchdog on; it only matters once that is off
        if (wr && paddr == `WDT_ADDR_CTRL) begin
            next_r.soft_en = pwdata[`WDT_EN_BIT];
        end
        if (wr && paddr == `WDT_ADDR_MASK) begin
            next_r.mask = pwdata[1:0];
        end
        if (wr && paddr == `WDT_ADDR_CFG) begin
            next_r.period_sel = pwdata[4:1];
            next_r.cfg_en = pwdata[0];
        end
        // sticky status, set wins
        // an event in the cycle of a write-one-to-clear stays set,
        // so no event is lost to a racing clear
        next_r.stat = (r.stat & ~w1c) | ev;
        // read data
        // loaded at the setup edge, zero in every other cycle
        // the word therefore stands for exactly the access phase
        next_r.prdata = 32'h0;
        if (rd_setup) begin
            unique case (paddr)
                `WDT_ADDR_CTRL: next_r.prdata = {31'h0, r.soft_en};
                `WDT_ADDR_CAUSE: next_r.prdata = {30'h0, r.timeout_flag, r.powerdown_flag};
                `WDT_ADDR_STAT: next_r.prdata = {30'h0, r.stat};
                `WDT_ADDR_MASK: next_r.prdata = {30'h0, r.mask};
                `WDT_ADDR_CFG: next_r.prdata = {27'h0, r.period_sel, r.cfg_en};
                default: next_r.prdata = 32'h0;
            endcase
        end
    end

    // state register; config bits come up as ones
    // only constants in the reset branch; the watchdog is therefore
    // running straight out of reset with the longest period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.st <= WDT_OFF;
            r.base_cnt <= 18'h0;
            r.post_cnt <= 16'h0;
            r.soft_en <= 1'b0;
            r.cfg_en <= `WDT_CFG_EN_RESET;
            r.period_sel <= `WDT_PS_RESET;
            r.timeout_flag <= 1'b1;
            r.powerdown_flag <= 1'b1;
            r.stat <= 2'h0;
            r.mask <= 2'h0;
            r.prdata <= 32'h0;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    // bus answers with no wait state and never signals an error
    // the event pulses leave the fire state directly: one cycle long
    assign prdata = r.prdata;
    assign pready = psel && penable; // one wait-free access
    assign pslverr = 1'b0;
    assign internal_rc_osc_en = running;
    assign dog_reset = (r.st == WDT_FIRE) && !sleeping;
    assign dog_wake = (r.st == WDT_FIRE) && sleeping;
    assign irq = |(r.stat & r.mask);

    // assertions
    // all sampled on pclk; the asserts, not the covers, are silenced while reset is asserted
    // counter clearing: any clear source leaves both counters at zero
    a_clear_zeroes: assert property (@(posedge pclk) disable iff (!presetn)
        clr |=> (r.base_cnt == 18'h0 && r.post_cnt == 16'h0))
        else $error("counters not cleared");
    a_fail_clears: assert property (@(posedge pclk) disable iff (!presetn)
        osc_fail |=> r.post_cnt == 16'h0)
        else $error("osc failure did not clear");
    a_force_run: assert property (@(posedge pclk) disable iff (!presetn)
        r.cfg_en |-> internal_rc_osc_en)
        else $error("config enable not forcing run");
    a_soft_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `WDT_ADDR_CTRL) |=> r.soft_en == $past(pwdata[0]))
        else $error("enable bit not written");
    // control reads: only the enable bit may be nonzero while the
    // word stands on the bus
    a_ctrl_upper: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && paddr == `WDT_ADDR_CTRL) |-> prdata[31:1] == 31'h0)
        else $error("upper control bits nonzero");
    // read data is dropped to zero outside a read
    a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_setup |=> prdata == 32'h0)
        else $error("read data left standing");
    // base period length in clock cycles
    a_base_len: assert property (@(posedge pclk) disable iff (!presetn)
        base_tick |-> r.base_cnt == 18'(`WDT_BASE_CYC - 1))
        else $error("base period wrong");
    // stopped watchdog never stays in the run state
    a_stop_leaves: assert property (@(posedge pclk) disable iff (!presetn)
        !running |=> r.st != WDT_RUN)
        else $error("run state kept while disabled");
    // clear instruction event is sticky and beats a clear write
    a_stat_set: assert property (@(posedge pclk) disable iff (!presetn)
        clear_dog_insn |=> r.stat[`WDT_EV_CLEAR])
        else $error("clear event not recorded");
    // a fire cycle sends exactly one of reset and wake
    a_fire_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == WDT_FIRE |-> (dog_reset ^ dog_wake))
        else $error("fire pulse missing");
    // clear instruction moves the cause flags to the clear pattern
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (clear_dog_insn && !expire) |=> (r.timeout_flag && r.powerdown_flag))
        else $error("cause flags not set by clear");
    a_tap_fire: assert property (@(posedge pclk) disable iff (!presetn)
        expire |=> (r.st == WDT_FIRE && !r.timeout_flag))
        else $error("expiry not acted on");
    a_fire_once: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == WDT_FIRE |=> r.st != WDT_FIRE)
        else $error("fire held too long");
    a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !running |=> (r.base_cnt == 18'h0 || running))
        else $error("counting while off");
    // main scenarios: reset fire, wake fire, clear while running, irq
    c_reset_fire: cover property (@(posedge pclk) dog_reset);
    c_wake_fire: cover property (@(posedge pclk) dog_wake);
    c_clear_insn: cover property (@(posedge pclk) clear_dog_insn && running);
    c_irq: cover property (@(posedge pclk) irq);
endmodule

// ===== test/watchdog_postscaled_timer_tb.sv
`timescale 1ns/1ps
`include "wdt_regs.svh"
module watchdog_postscaled_timer_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // bus side
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic sleep_insn = 1'b0, clear_dog_insn = 1'b0, sleeping = 1'b0, osc_fail = 1'b0; // core events
    logic [31:0] prdata;
    logic pready, pslverr, internal_rc_osc_en, dog_reset, dog_wake, irq;
    logic [31:0] rd; // last read word
    int failures = 0, check_count = 0;
    // 50 MHz clock
    always #10 pclk = ~pclk;
    wdt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_insn(sleep_insn), .clear_dog_insn(clear_dog_insn), .sleeping(sleeping),
        .osc_fail(osc_fail), .internal_rc_osc_en(internal_rc_osc_en), .dog_reset(dog_reset),
        .dog_wake(dog_wake), .irq(irq));
    // one apb transfer; read data is sampled at the taking edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // compare a value with its expectation
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read a register and compare
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // reset values of every register
    task automatic t_reset;
        rchk(`WDT_ADDR_CTRL, 32'h0);
        rchk(`WDT_ADDR_CAUSE, 32'h3);
        rchk(`WDT_ADDR_STAT, 32'h0);
        rchk(`WDT_ADDR_MASK, 32'h0);
        rchk(`WDT_ADDR_CFG, 32'h1F);
        chk({31'h0, internal_rc_osc_en}, 32'h1);
    endtask
    // software enable against the config enable
    task automatic t_enable;
        apb(1'b1, `WDT_ADDR_CTRL, 32'hFFFFFFFF);
        rchk(`WDT_ADDR_CTRL, 32'h1);
        apb(1'b1, `WDT_ADDR_CFG, 32'h1E);
        chk({31'h0, internal_rc_osc_en}, 32'h1);
        apb(1'b1, `WDT_ADDR_CTRL, 32'h0);
        chk({31'h0, internal_rc_osc_en}, 32'h0);
        rchk(`WDT_ADDR_CFG, 32'h1E);
        apb(1'b1, `WDT_ADDR_CFG, 32'h1F);
        chk({31'h0, internal_rc_osc_en}, 32'h1);
    endtask
    // sleep and clear events, flags and interrupt
    task automatic t_events;
        sleep_insn <= 1'b1;
        @(posedge pclk);
        sleep_insn <= 1'b0;
        @(posedge pclk);
        rchk(`WDT_ADDR_CAUSE, 32'h2);
        clear_dog_insn <= 1'b1;
        osc_fail <= 1'b1;
        @(posedge pclk);
        clear_dog_insn <= 1'b0;
        osc_fail <= 1'b0;
        @(posedge pclk);
        rchk(`WDT_ADDR_CAUSE, 32'h3);
        rchk(`WDT_ADDR_STAT, 32'h2);
        apb(1'b1, `WDT_ADDR_MASK, 32'h2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `WDT_ADDR_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `WDT_ADDR_MASK, 32'h2);
        apb(1'b1, `WDT_ADDR_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        rchk(`WDT_ADDR_STAT, 32'h0);
        chk({31'h0, dog_reset | dog_wake | pslverr}, 32'h0);
    endtask
    // unmapped place reads zero and ignores writes
    task automatic t_unmapped;
        apb(1'b1, 12'h0FC, 32'hA5A5A5A5);
        rchk(12'h0FC, 32'h0);
        rchk(`WDT_ADDR_CTRL, 32'h0);
    endtask
    // verdict and end of run
    task automatic finish_test;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_enable;
        t_events;
        t_unmapped;
        finish_test;
    end
    // hang guard
    initial begin
        #100000;
        failures++;
        finish_test;
    end
endmodule
